// >>> led_panel_pkg.sv
package led_panel_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_PANEL_BRIGHTNESS  = 8'h02;
    localparam logic [7:0] OFS_FIRST_DIGIT       = 8'h03;
    localparam logic [7:0] OFS_SECOND_DIGIT      = 8'h04;
    localparam logic [7:0] OFS_DRIVER_POINTER    = 8'h08;
    localparam logic [7:0] OFS_PANEL_SETTINGS    = 8'h0D;
    localparam logic [7:0] OFS_GRADUATION        = 8'h0E;

    // ==========================================================
    // Panel settings field positions
    localparam int POS_SHUTDOWN   = 0;
    localparam int POS_INVERT     = 1;
    localparam int POS_PLANE_LO   = 2;
    localparam int POS_PLANE_HI   = 3;
    localparam int POS_STAGGER    = 4;
    localparam int POS_FLIP       = 5;
    localparam int POS_COLOUR     = 6;
    localparam int POS_DEPTH      = 7;

    // Graduation field positions, value 1 means geometric
    localparam int POS_GRAD_FIRST  = 0;
    localparam int POS_GRAD_SECOND = 1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BRIGHTNESS = 8'hFF;
    localparam logic [7:0] RST_DIGIT      = 8'hFF;
    localparam logic [7:0] RST_POINTER    = 8'h00;
    localparam logic [7:0] RST_SETTINGS   = 8'h00;
    localparam logic [1:0] RST_GRADUATION = 2'h0;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ           = 100;
    localparam int OSC_KHZ           = 4194;
    localparam int OSC_DIV           = (CLK_MHZ * 1000) / OSC_KHZ;
    localparam int STAGGER_OSC       = 4;
    localparam int STAGGER_MAX_US    = 244;
    localparam int MAX_DRIVERS       = 256;
    localparam int STAGGER_TOTAL_US  = (MAX_DRIVERS - 1) * STAGGER_OSC * 1000 / OSC_KHZ;

endpackage : led_panel_pkg

// >>> led_panel_intensity_config.sv
// Function
// - Plane bits report active plane, read-only
// - Stagger bit delays timing by four oscillator periods
// - Total stagger offset stays within maximum delay
// - Flip bit reverses PWM on alternate drivers
// - Colour bit selects mono or red-green-yellow
// - Colour bit reads zero without multicolour support
// - Depth bit selects four or two planes
// - Depth bit reads zero without grey support
// - Graduation acts only in two-bit mode
// - Levels arithmetic thirds or geometric quarters
// - Separate graduation type per digit
// - Digit duty is n/256 of panel duty
// - First digit register holds n/256 code
// - Second digit register holds n/256 code
// - Panel code one gives 2/256 minimum
// - Driver pointer register holds full 8 bits
// - Even drivers normal, odd drivers reversed
// - Depth zero lit/dark pixels, one four-level
// - Colour one red-green-yellow, zero mono/RGB
`timescale 1ns/1ps
module led_panel_intensity_config #(
    parameter bit HAS_COLOUR = 1'b1,
    parameter bit HAS_GREY   = 1'b1,
    parameter int OSC_DIV    = led_panel_pkg::OSC_DIV
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Display inputs from same-clock logic
    input  wire logic [1:0] active_plane,
    input  wire logic [1:0] first_pixel_level,
    input  wire logic [1:0] second_pixel_level,
    // Drive outputs
    output logic            first_digit_drive,
    output logic            second_digit_drive,
    output logic            colour_rgy,
    output logic            plane_depth_select
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  panel_brightness;
        logic [7:0]  first_digit_brightness;
        logic [7:0]  second_digit_brightness;
        logic [7:0]  driver_pointer;
        logic        shutdown;
        logic        invert;
        logic        stagger;
        logic        flip;
        logic        colour;
        logic        depth;
        logic [1:0]  graduation;
        logic [15:0] div_cnt;
        logic [7:0]  pwm_cnt;
        logic [1:0]  frame_mod3;
        logic [1:0]  frame_mod4;
        logic [7:0]  rdata;
        logic        drive0;
        logic        drive1;
        logic        rgy;
        logic        depth_out;
    } state_t;

    state_t st;
    state_t next_st;

    // ==========================================================
    // Address decode
    typedef struct packed {
        logic panel;
        logic first;
        logic second;
        logic pointer;
        logic settings;
        logic graduation;
    } reg_sel_t;

    // One decoder serves both the write and the read path
    function automatic reg_sel_t reg_select(input logic [7:0] addr);
        reg_select = '0;
        if (addr == led_panel_pkg::OFS_PANEL_BRIGHTNESS)
            reg_select.panel = 1'b1;
        else if (addr == led_panel_pkg::OFS_FIRST_DIGIT)
            reg_select.first = 1'b1;
        else if (addr == led_panel_pkg::OFS_SECOND_DIGIT)
            reg_select.second = 1'b1;
        else if (addr == led_panel_pkg::OFS_DRIVER_POINTER)
            reg_select.pointer = 1'b1;
        else if (addr == led_panel_pkg::OFS_PANEL_SETTINGS)
            reg_select.settings = 1'b1;
        else if (addr == led_panel_pkg::OFS_GRADUATION)
            reg_select.graduation = 1'b1;
    endfunction : reg_select

    // ==========================================================
    // Helpers
    function automatic logic [8:0] panel_duty(input logic [7:0] code);
        // Code 0 gives zero duty, codes 1 and 2 both give the 2/256 minimum
        if (code == 8'h00)
            panel_duty = 9'h000;
        else if (code <= 8'h02)
            panel_duty = 9'h002;
        else
            panel_duty = {1'b0, code};
    endfunction : panel_duty

    // Digit duty scales the panel duty by n/256
    function automatic logic [8:0] digit_duty(input logic [7:0] n, input logic [8:0] panel);
        logic [16:0] prod;
        prod = {8'h00, n} * {8'h00, panel};
        digit_duty = prod[16:8];
    endfunction : digit_duty

    // Arithmetic scale: level 1 lit one frame in three, level 2 two in three
    function automatic logic arith_lit(input logic [1:0] level, input logic [1:0] f3);
        case (level)
            2'h3:    arith_lit = 1'b1;
            2'h2:    arith_lit = (f3 != 2'h1);
            2'h1:    arith_lit = (f3 == 2'h1);
            default: arith_lit = 1'b0;
        endcase
    endfunction : arith_lit

    // Geometric scale: level 1 lit one frame in four, level 2 every other
    function automatic logic geo_lit(input logic [1:0] level, input logic [1:0] f4);
        case (level)
            2'h3:    geo_lit = 1'b1;
            2'h2:    geo_lit = !f4[0];
            2'h1:    geo_lit = (f4 == 2'h1);
            default: geo_lit = 1'b0;
        endcase
    endfunction : geo_lit

    function automatic logic pixel_lit(input logic [1:0] level, input logic grey,
                                       input logic geometric, input logic [1:0] f3,
                                       input logic [1:0] f4);
        if (!grey)
            pixel_lit = level[0];
        else if (geometric)
            pixel_lit = geo_lit(level, f4);
        else
            pixel_lit = arith_lit(level, f3);
    endfunction : pixel_lit

    // Reversed timing puts the lit span at the end of the period
    function automatic logic pwm_high(input logic [7:0] phase, input logic [8:0] duty,
                                      input logic reverse);
        if (reverse)
            pwm_high = ({1'b0, phase} >= (9'h100 - duty));
        else
            pwm_high = ({1'b0, phase} < duty);
    endfunction : pwm_high

    // Frame counter modulo three
    function automatic logic [1:0] next_mod3(input logic [1:0] f3);
        if (f3 == 2'h2)
            next_mod3 = 2'h0;
        else
            next_mod3 = f3 + 2'h1;
    endfunction : next_mod3

    // Settings readback: plane bits come live from the plane logic
    function automatic logic [7:0] settings_word(input state_t s, input logic [1:0] plane,
                                                 input logic grey_mode);
        settings_word                              = 8'h00;
        settings_word[led_panel_pkg::POS_SHUTDOWN] = s.shutdown;
        settings_word[led_panel_pkg::POS_INVERT]   = s.invert;
        settings_word[led_panel_pkg::POS_PLANE_LO] = plane[0];
        settings_word[led_panel_pkg::POS_PLANE_HI] = plane[1];
        settings_word[led_panel_pkg::POS_STAGGER]  = s.stagger;
        settings_word[led_panel_pkg::POS_FLIP]     = s.flip;
        settings_word[led_panel_pkg::POS_COLOUR]   = s.colour && HAS_COLOUR;
        settings_word[led_panel_pkg::POS_DEPTH]    = grey_mode;
    endfunction : settings_word

    // ==========================================================
    // Next state
    logic [8:0] pdut;
    logic [8:0] d0dut;
    logic [8:0] d1dut;
    logic [7:0] phase;
    logic       reverse;
    logic       grey;
    logic       osc_tick;
    reg_sel_t   sel;
    logic       pwm0;
    logic       pwm1;
    logic       lit0;
    logic       lit1;

    always_comb
    begin
        next_st  = st;
        sel      = reg_select(reg_addr);
        pdut     = panel_duty(st.panel_brightness);
        d0dut    = digit_duty(st.first_digit_brightness, pdut);
        d1dut    = digit_duty(st.second_digit_brightness, pdut);
        // Stagger offset is the low six driver address bits times four oscillator periods
        if (st.stagger)
            phase = st.pwm_cnt - {st.driver_pointer[5:0], 2'h0};
        else
            phase = st.pwm_cnt;
        reverse  = st.flip && st.driver_pointer[0];
        grey     = st.depth && HAS_GREY;
        osc_tick = (st.div_cnt == 16'(OSC_DIV - 1));

        // Multiplex oscillator divider and PWM counter
        if (osc_tick)
        begin
            next_st.div_cnt = 16'h0000;
            next_st.pwm_cnt = st.pwm_cnt + 8'h01;
            if (st.pwm_cnt == 8'hFF)
            begin
                // Frame counters pace the pixel-level modulation
                next_st.frame_mod3 = next_mod3(st.frame_mod3);
                next_st.frame_mod4 = st.frame_mod4 + 2'h1;
            end
        end
        else
        begin
            next_st.div_cnt = st.div_cnt + 16'h0001;
        end

        // Register writes
        if (reg_wr)
        begin
            if (sel.panel)
            begin
                next_st.panel_brightness = reg_wdata;
            end
            else if (sel.first)
            begin
                next_st.first_digit_brightness = reg_wdata;
            end
            else if (sel.second)
            begin
                next_st.second_digit_brightness = reg_wdata;
            end
            else if (sel.pointer)
            begin
                next_st.driver_pointer = reg_wdata;
            end
            else if (sel.settings)
            begin
                // Plane bits are not stored: writes to them are dropped
                next_st.shutdown = reg_wdata[led_panel_pkg::POS_SHUTDOWN];
                next_st.invert   = reg_wdata[led_panel_pkg::POS_INVERT];
                next_st.stagger  = reg_wdata[led_panel_pkg::POS_STAGGER];
                next_st.flip     = reg_wdata[led_panel_pkg::POS_FLIP];
                next_st.colour   = reg_wdata[led_panel_pkg::POS_COLOUR]
                                   && HAS_COLOUR;
                next_st.depth    = reg_wdata[led_panel_pkg::POS_DEPTH]
                                   && HAS_GREY;
            end
            else if (sel.graduation)
            begin
                next_st.graduation = reg_wdata[1:0];
            end
        end

        // Register reads, data in the following cycle only
        next_st.rdata = 8'h00;
        if (reg_rd)
        begin
            if (sel.panel)
            begin
                next_st.rdata = st.panel_brightness;
            end
            else if (sel.first)
            begin
                next_st.rdata = st.first_digit_brightness;
            end
            else if (sel.second)
            begin
                next_st.rdata = st.second_digit_brightness;
            end
            else if (sel.pointer)
            begin
                next_st.rdata = st.driver_pointer;
            end
            else if (sel.settings)
            begin
                next_st.rdata = settings_word(st, active_plane, grey);
            end
            else if (sel.graduation)
            begin
                next_st.rdata = {6'h00, st.graduation};
            end
        end

        // Digit drive: PWM gated by pixel level
        pwm0 = pwm_high(phase, d0dut, reverse);
        pwm1 = pwm_high(phase, d1dut, reverse);
        lit0 = pixel_lit(first_pixel_level, grey, st.graduation[led_panel_pkg::POS_GRAD_FIRST],
                         st.frame_mod3, st.frame_mod4);
        lit1 = pixel_lit(second_pixel_level, grey, st.graduation[led_panel_pkg::POS_GRAD_SECOND],
                         st.frame_mod3, st.frame_mod4);
        // Shutdown blanks both digits
        if (st.shutdown)
        begin
            next_st.drive0 = 1'b0;
            next_st.drive1 = 1'b0;
        end
        else
        begin
            next_st.drive0 = pwm0 && lit0;
            next_st.drive1 = pwm1 && lit1;
        end
        next_st.rgy       = st.colour && HAS_COLOUR;
        next_st.depth_out = grey;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st                         <= '0;
            st.panel_brightness        <= led_panel_pkg::RST_BRIGHTNESS;
            st.first_digit_brightness  <= led_panel_pkg::RST_DIGIT;
            st.second_digit_brightness <= led_panel_pkg::RST_DIGIT;
            st.driver_pointer          <= led_panel_pkg::RST_POINTER;
            st.graduation              <= led_panel_pkg::RST_GRADUATION;
        end
        else
            st <= next_st;
    end

    assign reg_rdata          = st.rdata;
    assign first_digit_drive  = st.drive0;
    assign second_digit_drive = st.drive1;
    assign colour_rgy         = st.rgy;
    assign plane_depth_select = st.depth_out;

endmodule : led_panel_intensity_config

// >>> led_panel_intensity_config_monitor.sv
`timescale 1ns/1ps
module led_panel_intensity_config_monitor #(
    parameter bit HAS_COLOUR = 1'b1,
    parameter bit HAS_GREY   = 1'b1
) (
    // Clock, reset, register port
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Display side
    input wire logic [1:0] active_plane,
    input wire logic       first_digit_drive,
    input wire logic       second_digit_drive,
    input wire logic       colour_rgy,
    input wire logic       plane_depth_select
);
    localparam logic [7:0] SET = led_panel_pkg::OFS_PANEL_SETTINGS;
    logic [7:0] sh [16];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            sh <= '{8: 8'h00, default: 8'hFF};
        else if (reg_wr && reg_addr[7:4] == 4'h0)
            sh[reg_addr[3:0]] <= reg_wdata;
    property p_plane_ro; reg_rd && reg_addr == SET |=> reg_rdata[3:2] == $past(active_plane); endproperty
    a_plane_ro: assert property (p_plane_ro) else $error("plane field");
    property p_colour; reg_wr && reg_addr == SET |-> ##2 colour_rgy == (HAS_COLOUR && $past(reg_wdata[6], 2)); endproperty
    a_colour: assert property (p_colour) else $error("colour bit");
    property p_depth; reg_wr && reg_addr == SET |-> ##2 plane_depth_select == (HAS_GREY && $past(reg_wdata[7], 2)); endproperty
    a_depth: assert property (p_depth) else $error("depth bit");
    property p_zero0; (sh[3] == 8'h00) [*3] |-> !first_digit_drive; endproperty
    a_zero0: assert property (p_zero0) else $error("digit 0 lit");
    property p_zero1; (sh[4] == 8'h00) [*3] |-> !second_digit_drive; endproperty
    a_zero1: assert property (p_zero1) else $error("digit 1 lit");
    property p_off; (sh[2] == 8'h00) [*3] |-> !first_digit_drive && !second_digit_drive; endproperty
    a_off: assert property (p_off) else $error("panel lit");
    property p_ptr_rd; reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(sh[8]); endproperty
    a_ptr_rd: assert property (p_ptr_rd) else $error("pointer read");
    property p_dig_rd; reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(sh[3]); endproperty
    a_dig_rd: assert property (p_dig_rd) else $error("digit read");
endmodule : led_panel_intensity_config_monitor
bind led_panel_intensity_config led_panel_intensity_config_monitor #(.HAS_COLOUR(HAS_COLOUR),
    .HAS_GREY(HAS_GREY)) led_panel_intensity_config_monitor_i (.ref_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .active_plane, .first_digit_drive,
    .second_digit_drive, .colour_rgy, .plane_depth_select);

// >>> host.sv
`timescale 1ns/1ps
module host (
    // Clock
    input  wire logic       ref_clk,
    // Register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask : rd
endmodule : host

// >>> tb_led_panel_intensity_config.sv
`timescale 1ns/1ps
module tb_led_panel_intensity_config;
    localparam int DIV = 2;
    localparam int FR [2][4] = '{'{0, 4, 8, 12}, '{0, 3, 6, 12}};
    localparam logic [7:0] OFS [6] = '{8'h02, 8'h03, 8'h04, 8'h08, 8'h0E, 8'h05};
    localparam logic [7:0] RST [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] SET = led_panel_pkg::OFS_PANEL_SETTINGS;
    logic       ref_clk = 1'b0;
    logic       arst_n, reg_wr, reg_rd, colour_rgy, plane_depth_select;
    logic       first_digit_drive, second_digit_drive;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, pan, n0, n1;
    logic [1:0] active_plane, first_pixel_level, second_pixel_level;
    int         bad_count = 0;
    int         n_tests = 0;
    led_panel_intensity_config #(.OSC_DIV(DIV)) led_panel_intensity_config_i (.ref_clk,
        .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .active_plane,
        .first_pixel_level, .second_pixel_level, .first_digit_drive, .second_digit_drive,
        .colour_rgy, .plane_depth_select);
    host host_i (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // Lit cycles over whole PWM periods, so the phase offset drops out
    task automatic measure(input int p, input int e0, input int e1);
        int c0 = 0, c1 = 0;
        repeat (4) @(posedge ref_clk);
        repeat (p * 256 * DIV)
        begin
            @(posedge ref_clk);
            c0 += int'(first_digit_drive === 1'b1);
            c1 += int'(second_digit_drive === 1'b1);
        end
        chk(c0, e0);
        chk(c1, e1);
    endtask : measure
    function automatic int exp_lit(logic [7:0] pn, logic [7:0] n, logic dp, logic gr,
                                  logic [1:0] lv, int p);
        int d;
        d = (pn == 8'h00) ? 0 : (pn < 8'h03) ? 2 : int'(pn);
        return ((n * d) >> 8) * DIV * p * (dp ? FR[gr][lv] : 12 * lv[0]) / 12;
    endfunction : exp_lit
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    initial
    begin
        #500_000;
        bad_count++;
        test_done();
    end
    initial
    begin
        {arst_n, active_plane, first_pixel_level, second_pixel_level} = '0;
        v = 8'($urandom(77));
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        active_plane <= 2'($urandom);
        foreach (OFS[i])
        begin
            host_i.rd(OFS[i], v);
            chk(v, RST[i]);
        end
        host_i.wr(SET, 8'hCC);
        host_i.rd(SET, v);
        chk(v, {4'hC, active_plane, 2'h0});
        chk({colour_rgy, plane_depth_select}, 2'h3);
        host_i.wr(SET, 8'h80);
        host_i.wr(led_panel_pkg::OFS_GRADUATION, 8'h02);
        for (int lv = 0; lv < 4; lv++)
        begin
            first_pixel_level <= 2'(lv);
            second_pixel_level <= 2'(lv);
            measure(12, exp_lit(8'hFF, 8'hFF, 1'b1, 1'b0, 2'(lv), 12),
                    exp_lit(8'hFF, 8'hFF, 1'b1, 1'b1, 2'(lv), 12));
        end
        for (int i = 0; i < 10; i++)
        begin
            pan = (i < 4) ? 8'(i) : 8'($urandom);
            n0 = (i == 1) ? 8'h00 : (i == 4) ? 8'hFF : 8'($urandom);
            n1 = (i == 3) ? 8'h00 : 8'($urandom);
            first_pixel_level <= 2'($urandom);
            second_pixel_level <= 2'($urandom);
            host_i.wr(SET, {1'b0, 3'($urandom), 4'h0});
            host_i.wr(8'h02, pan);
            host_i.wr(8'h03, n0);
            host_i.wr(8'h04, n1);
            host_i.wr(8'h08, (i == 0) ? 8'hFF : 8'($urandom));
            measure(1, exp_lit(pan, n0, 1'b0, 1'b0, first_pixel_level, 1),
                    exp_lit(pan, n1, 1'b0, 1'b0, second_pixel_level, 1));
        end
        test_done();
    end
endmodule : tb_led_panel_intensity_config
